// ===== rtl/irqf_flag_bank.sv
// Purpose: interrupt request flags with mask, priority and pin edge selection
// Assumes: one 50 MHz clock, synchronous active-low reset, peripherals on the same clock
// Notes: the status word lives in the cpu; its enable and in-service bits arrive as inputs
`timescale 1ns/1ps
`include "irqf_regs.svh"

// Summary of operation
// R1 - a flag sets on its source request or on a software write of one
// R2 - a flag clears on software clear, on acknowledge, or on reset
// R3 - acknowledging a request clears its flag before the service routine starts
// R4 - all three flag registers take single-bit and whole-byte writes
// R5 - the first two flag registers also take one 16-bit write, low byte first
// R6 - reset loads every flag register with zero
// R7 - the shared serial flag sets on either of its two sources
// R8 - one shared mask and one shared priority bit govern both serial sources
// R9 - first register: low voltage, pins 0 to 5, serial receive error
// R10 - second register: receive end, transmit end, shared serial, five timer sources
// R11 - third register: a/d, receiver two, interval, timer, key, watch; bits 6-7 zero
// R12 - a flag of one means pending, zero means nothing raised
// R13 - each source has mask and priority bits at its flag's position
// R14 - control uses flags, masks, priorities, both edge enables and the status word
// R15 - only a flagged and unmasked request may be offered for acknowledge
// R16 - equal programmed priority falls back to fixed order, index zero highest
// R17 - software clears flags by single-bit clear to avoid losing fresh requests
// R18 - a request arriving with a clear wins, so the event is not lost
module irqf_flag_bank #(
    parameter int NUM_PINS = 6
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire irqf_pkg::irqf_cpu_req_t cpuReq,
    output logic [7:0] cpuRdata,
    input wire irqf_pkg::irqf_ack_t ack,
    input wire logic globalIrqEnable,
    input wire logic inServicePriority,
    output irqf_pkg::irqf_grant_t grant,
    input wire logic [`IRQF_NUM_SOURCES-1:0] periphIrq,
    input wire logic clockedSerialIrq,
    input wire logic serial2TxIrq,
    input wire logic [NUM_PINS-1:0] extPin
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] irqPendingLow0, irqPendingHigh0, irqPendingLow1;
    logic [7:0] irqMaskLow0, irqMaskHigh0, irqMaskLow1;
    logic [7:0] irqPrioLow0, irqPrioHigh0, irqPrioLow1;
    logic [7:0] riseEdgeEnable, fallEdgeEnable;
    logic [NUM_PINS-1:0] pinSync0, pinSync1, pinSync2, pinLevel, pinLevelQ;

    // ----------------------------------------------------------------
    // byte update from cpu access
    // ----------------------------------------------------------------
    function automatic logic [7:0] applyByte(input logic [7:0] cur, input logic [15:0] regAddr,
                                              input irqf_pkg::irqf_cpu_req_t req);
        logic [7:0] res;
        logic pairBase;
        res = cur;
        // R5 only the flag, mask and priority pairs take 16-bit writes
        pairBase = req.addr == `IRQF_PEND_LOW0_ADDR || req.addr == `IRQF_MASK_LOW0_ADDR
                   || req.addr == `IRQF_PRIO_LOW0_ADDR;
        if (req.wrByte && req.addr == regAddr) begin
            res = req.wdata[7:0];
        end else if (req.wrWord && pairBase && req.addr == regAddr && !regAddr[0]) begin
            res = req.wdata[7:0];
        end else if (req.wrWord && pairBase && req.addr == regAddr - 16'h0001 && regAddr[0]) begin
            res = req.wdata[15:8];
        end else if (req.bitOp && req.addr == regAddr) begin
            res[req.bitIdx] = req.bitVal;
        end
        return res;
    endfunction

    // lowest index wins: fixed default order
    function automatic logic [4:0] firstSet(input logic [`IRQF_NUM_SOURCES-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = `IRQF_NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // ----------------------------------------------------------------
    // pin edge detection
    // ----------------------------------------------------------------
    wire [NUM_PINS-1:0] pinRise = pinLevel & ~pinLevelQ & riseEdgeEnable[NUM_PINS-1:0];
    wire [NUM_PINS-1:0] pinFall = ~pinLevel & pinLevelQ & fallEdgeEnable[NUM_PINS-1:0];
    wire [NUM_PINS-1:0] pinSettled = ~(pinSync1 ^ pinSync2);

    always_ff @(posedge clk) begin
        pinSync0 <= extPin;
        pinSync1 <= pinSync0;
        pinSync2 <= pinSync1;
    end

    // a change counts only once two stages agree; filters a single-cycle glitch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinLevel <= '0;
            pinLevelQ <= '0;
        end else begin
            pinLevel <= (pinSettled & pinSync2) | (~pinSettled & pinLevel);
            pinLevelQ <= pinLevel;
        end
    end

    // ----------------------------------------------------------------
    // hardware set and acknowledge clear
    // ----------------------------------------------------------------
    // R1 R9 R10 source set positions
    wire [23:0] pinSetVec = 24'({pinRise | pinFall}) << `IRQF_PIN_FIRST_BIT;
    // R7 shared serial set
    wire [23:0] sharedSetVec = 24'({clockedSerialIrq | serial2TxIrq}) << `IRQF_SHARED_SERIAL_BIT;
    wire [23:0] hwSet = {2'b00, periphIrq} | pinSetVec | sharedSetVec;
    // R3 acknowledge clear
    wire [23:0] ackClear = ack.strobe ? (24'h000001 << ack.index) : 24'h000000;

    wire [7:0] swLow0 = applyByte(irqPendingLow0, `IRQF_PEND_LOW0_ADDR, cpuReq);
    wire [7:0] swHigh0 = applyByte(irqPendingHigh0, `IRQF_PEND_HIGH0_ADDR, cpuReq);
    wire [7:0] swLow1 = applyByte(irqPendingLow1, `IRQF_PEND_LOW1_ADDR, cpuReq);

    // R2 R12 clears drop the pending one
    // R18 set beats clear
    wire [23:0] next_flags = ({swLow1, swHigh0, swLow0} & ~ackClear) | hwSet;
    wire [7:0] next_maskLow0 = applyByte(irqMaskLow0, `IRQF_MASK_LOW0_ADDR, cpuReq);
    wire [7:0] next_maskHigh0 = applyByte(irqMaskHigh0, `IRQF_MASK_HIGH0_ADDR, cpuReq);
    wire [7:0] next_maskLow1 = applyByte(irqMaskLow1, `IRQF_MASK_LOW1_ADDR, cpuReq);
    wire [7:0] next_prioLow0 = applyByte(irqPrioLow0, `IRQF_PRIO_LOW0_ADDR, cpuReq);
    wire [7:0] next_prioHigh0 = applyByte(irqPrioHigh0, `IRQF_PRIO_HIGH0_ADDR, cpuReq);
    wire [7:0] next_prioLow1 = applyByte(irqPrioLow1, `IRQF_PRIO_LOW1_ADDR, cpuReq);

    // ----------------------------------------------------------------
    // flag, mask, priority and edge registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // R6 clear on reset
            irqPendingLow0 <= `IRQF_PEND_RESET;
            irqPendingHigh0 <= `IRQF_PEND_RESET;
            irqPendingLow1 <= `IRQF_PEND_RESET;
        end else begin
            // R4 byte and bit writes
            irqPendingLow0 <= next_flags[7:0];
            irqPendingHigh0 <= next_flags[15:8];
            // R11 top bits fixed zero
            irqPendingLow1 <= next_flags[23:16] & `IRQF_LOW1_USED;
        end
    end

    // R13 mask and priority per source
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irqMaskLow0 <= `IRQF_MASK_RESET;
            irqMaskHigh0 <= `IRQF_MASK_RESET;
            irqMaskLow1 <= `IRQF_MASK_RESET;
            irqPrioLow0 <= `IRQF_PRIO_RESET;
            irqPrioHigh0 <= `IRQF_PRIO_RESET;
            irqPrioLow1 <= `IRQF_PRIO_RESET;
        end else begin
            irqMaskLow0 <= next_maskLow0;
            irqMaskHigh0 <= next_maskHigh0;
            irqMaskLow1 <= next_maskLow1 | ~`IRQF_LOW1_USED;
            irqPrioLow0 <= next_prioLow0;
            irqPrioHigh0 <= next_prioHigh0;
            irqPrioLow1 <= next_prioLow1 | ~`IRQF_LOW1_USED;
        end
    end

    // R14 edge enable registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            riseEdgeEnable <= `IRQF_EDGE_RESET;
            fallEdgeEnable <= `IRQF_EDGE_RESET;
        end else begin
            riseEdgeEnable <= applyByte(riseEdgeEnable, `IRQF_RISE_EDGE_ADDR, cpuReq) & `IRQF_EDGE_USED;
            fallEdgeEnable <= applyByte(fallEdgeEnable, `IRQF_FALL_EDGE_ADDR, cpuReq) & `IRQF_EDGE_USED;
        end
    end

    // ----------------------------------------------------------------
    // arbitration on the values the registers take next
    // ----------------------------------------------------------------
    wire [23:0] next_mask = {next_maskLow1, next_maskHigh0, next_maskLow0};
    wire [23:0] next_prio = {next_prioLow1, next_prioHigh0, next_prioLow0};
    // R8 bit ten serves both serial lines
    // R15 flagged and unmasked
    wire [`IRQF_NUM_SOURCES-1:0] eligible = next_flags[`IRQF_NUM_SOURCES-1:0] & ~next_mask[`IRQF_NUM_SOURCES-1:0];
    wire [`IRQF_NUM_SOURCES-1:0] eligibleHigh = eligible & ~next_prio[`IRQF_NUM_SOURCES-1:0];
    // low level is held off while a high-level routine runs
    wire [`IRQF_NUM_SOURCES-1:0] eligibleLow = inServicePriority ? eligible : '0;
    wire pickHigh = |eligibleHigh;
    // R16 level first, then fixed order
    wire [4:0] pickIndex = pickHigh ? firstSet(eligibleHigh) : firstSet(eligibleLow);
    wire pickValid = globalIrqEnable && (pickHigh || |eligibleLow);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            grant <= '0;
        end else begin
            grant.valid <= pickValid;
            // idle grant reads as all zero so the cpu never sees a stale index
            grant.index <= pickValid ? pickIndex : 5'h00;
            grant.prio <= pickValid && !pickHigh;
        end
    end

    // ----------------------------------------------------------------
    // cpu read port, one cycle latency
    // ----------------------------------------------------------------
    wire [7:0] readMux =
        (cpuReq.addr == `IRQF_PEND_LOW0_ADDR) ? irqPendingLow0 :
        (cpuReq.addr == `IRQF_PEND_HIGH0_ADDR) ? irqPendingHigh0 :
        (cpuReq.addr == `IRQF_PEND_LOW1_ADDR) ? irqPendingLow1 :
        (cpuReq.addr == `IRQF_MASK_LOW0_ADDR) ? irqMaskLow0 :
        (cpuReq.addr == `IRQF_MASK_HIGH0_ADDR) ? irqMaskHigh0 :
        (cpuReq.addr == `IRQF_MASK_LOW1_ADDR) ? irqMaskLow1 :
        (cpuReq.addr == `IRQF_PRIO_LOW0_ADDR) ? irqPrioLow0 :
        (cpuReq.addr == `IRQF_PRIO_HIGH0_ADDR) ? irqPrioHigh0 :
        (cpuReq.addr == `IRQF_PRIO_LOW1_ADDR) ? irqPrioLow1 :
        (cpuReq.addr == `IRQF_RISE_EDGE_ADDR) ? riseEdgeEnable :
        (cpuReq.addr == `IRQF_FALL_EDGE_ADDR) ? fallEdgeEnable : `IRQF_UNMAPPED_READ;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpuRdata <= 8'h00;
        end else begin
            cpuRdata <= cpuReq.rdEn ? readMux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    wire [23:0] flagVec = {irqPendingLow1, irqPendingHigh0, irqPendingLow0};
    wire [23:0] maskVec = {irqMaskLow1, irqMaskHigh0, irqMaskLow0};
    wire [23:0] prioVec = {irqPrioLow1, irqPrioHigh0, irqPrioLow0};

    hw_set_a: assert property (hwSet[0] |=> irqPendingLow0[0]) // R1
        else $error("source request did not set its flag");
    bit_set_a: assert property (cpuReq.bitOp && cpuReq.bitVal && cpuReq.addr == `IRQF_PEND_HIGH0_ADDR // R4
        && !ack.strobe |=> irqPendingHigh0[$past(cpuReq.bitIdx)])
        else $error("single-bit set was not taken");
    ack_clear_a: assert property (ack.strobe && !hwSet[ack.index] && !cpuReq.bitOp && !cpuReq.wrByte // R3
        && !cpuReq.wrWord |=> !flagVec[$past(ack.index)])
        else $error("acknowledged flag still set");
    word_write_a: assert property (cpuReq.wrWord && cpuReq.addr == `IRQF_PEND_LOW0_ADDR && !ack.strobe // R5
        && hwSet[15:0] == 16'h0000 |=> {irqPendingHigh0, irqPendingLow0} == $past(cpuReq.wdata))
        else $error("16-bit write landed wrongly");
    reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // R6
        !reset_n |=> flagVec == 24'h000000)
        else $error("flags not zero after reset");
    low1_top_a: assert property (irqPendingLow1[7:6] == 2'b00) // R11
        else $error("fixed flag bits became one");
    shared_set_a: assert property (clockedSerialIrq || serial2TxIrq |=> irqPendingHigh0[2]) // R7
        else $error("shared serial flag missed");
    grant_ok_a: assert property (grant.valid |-> flagVec[grant.index] && !maskVec[grant.index]) // R15
        else $error("grant for masked or idle source");
    grant_level_a: assert property (grant.valid && grant.prio |-> // R16
        (flagVec[21:0] & ~maskVec[21:0] & ~prioVec[21:0]) == 22'h000000)
        else $error("low level granted over high level");

    // edge reaches the flag four edges after the pin is first sampled high; set wins any clear there
    sequence pinRiseHeld;
        $rose(extPin[0]) ##0 (riseEdgeEnable[0] && !pinLevel[0] && !pinSync1[0] && !pinSync2[0])
            ##1 (extPin[0] && riseEdgeEnable[0])[*4];
    endsequence
    pin_edge_a: assert property (pinRiseHeld |=> irqPendingLow0[1]) // R9
        else $error("pin rising edge not flagged");

endmodule

// ===== rtl/irqf_pkg.sv
// Purpose: types shared by the irq flag bank and its surroundings
// Assumes: nothing beyond the constants header
// Notes: carriers for cpu access, acknowledge and grant
package irqf_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic rdEn;
        logic wrByte;
        logic wrWord;
        logic bitOp;
        logic bitVal;
        logic [2:0] bitIdx;
        logic [15:0] wdata;
    } irqf_cpu_req_t;

    typedef struct packed {
        logic strobe;
        logic [4:0] index;
    } irqf_ack_t;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic prio;
    } irqf_grant_t;

endpackage

// ===== rtl/irqf_regs.svh
// Purpose: addresses, field positions, reset values and counts of the irq flag bank
// Assumes: byte-addressed cpu data space, 16-bit addresses
// Notes: included by the flag bank module and by the testbench
`ifndef IRQF_REGS_SVH
`define IRQF_REGS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define IRQF_PEND_LOW0_ADDR 16'hFFE0
`define IRQF_PEND_HIGH0_ADDR 16'hFFE1
`define IRQF_PEND_LOW1_ADDR 16'hFFE2
`define IRQF_MASK_LOW0_ADDR 16'hFFE4
`define IRQF_MASK_HIGH0_ADDR 16'hFFE5
`define IRQF_MASK_LOW1_ADDR 16'hFFE6
`define IRQF_PRIO_LOW0_ADDR 16'hFFE8
`define IRQF_PRIO_HIGH0_ADDR 16'hFFE9
`define IRQF_PRIO_LOW1_ADDR 16'hFFEA
`define IRQF_RISE_EDGE_ADDR 16'hFF48
`define IRQF_FALL_EDGE_ADDR 16'hFF49

// ----------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------
`define IRQF_PEND_RESET 8'h00
`define IRQF_MASK_RESET 8'hFF
`define IRQF_PRIO_RESET 8'hFF
`define IRQF_EDGE_RESET 8'h00
`define IRQF_LOW1_USED 8'h3F
`define IRQF_EDGE_USED 8'h3F
`define IRQF_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// source positions in the 24-bit flag vector
// ----------------------------------------------------------------
`define IRQF_NUM_SOURCES 22
`define IRQF_PIN_FIRST_BIT 1
`define IRQF_SHARED_SERIAL_BIT 10
`define IRQF_SYNC_STAGES 3

`endif

// ===== tb/irqf_cpu_model.sv
// Purpose: cpu side of the flag bank, acknowledging what is granted
// Assumes: grant is a registered level from the flag bank
// Notes: waits ackDelay cycles before each acknowledge, so it can be prompt or slow
`timescale 1ns/1ps
module irqf_cpu_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ackEnable,
    input wire logic [3:0] ackDelay,
    input wire irqf_pkg::irqf_grant_t grant,
    output irqf_pkg::irqf_ack_t ack
);
    logic [3:0] waitCnt;

    initial ack = '0;

    // one strobe per grant; skip the cycle after a strobe so the cleared flag is seen first
    always @(negedge clk) begin
        if (!reset_n || !ackEnable) begin
            ack <= '0;
            waitCnt <= 4'h0;
        end else if (grant.valid && !ack.strobe && waitCnt >= ackDelay) begin
            ack <= '{strobe: 1'b1, index: grant.index};
            waitCnt <= 4'h0;
        end else begin
            ack <= '0;
            if (grant.valid && !ack.strobe) begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule

// ===== tb/test_interrupt_request_flag_bank.sv
// Purpose: self-checking bench for the irq flag bank
// Assumes: inputs change at the falling edge, one access at a time
// Notes: flag index equals fixed default order; sources 22 and 23 are the shared serial lines
`timescale 1ns/1ps
`include "irqf_regs.svh"
module test_interrupt_request_flag_bank;
    logic clk;
    logic reset_n;
    irqf_pkg::irqf_cpu_req_t cpuReq;
    irqf_pkg::irqf_ack_t ack;
    irqf_pkg::irqf_grant_t grant;
    logic [7:0] cpuRdata;
    logic globalIrqEnable;
    logic inServicePriority;
    logic [21:0] periphIrq;
    logic clockedSerialIrq;
    logic serial2TxIrq;
    logic [5:0] extPin;
    logic ackEnable;
    int n_fail;
    int samples_checked;
    int i;
    int k;

    irqf_flag_bank i_irqf_flag_bank (.clk(clk), .reset_n(reset_n), .cpuReq(cpuReq),
        .cpuRdata(cpuRdata), .ack(ack), .globalIrqEnable(globalIrqEnable),
        .inServicePriority(inServicePriority), .grant(grant), .periphIrq(periphIrq),
        .clockedSerialIrq(clockedSerialIrq), .serial2TxIrq(serial2TxIrq), .extPin(extPin));
    irqf_cpu_model i_irqf_cpu_model (.clk(clk), .reset_n(reset_n), .ackEnable(ackEnable),
        .ackDelay(4'h2), .grant(grant), .ack(ack));

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    // op bits: read, byte write, word write, bit write
    task automatic bus(input logic [15:0] a, input logic [3:0] op, input logic bv, input logic [2:0] bi,
                       input logic [15:0] d);
        @(negedge clk);
        cpuReq <= '{addr: a, rdEn: op[3], wrByte: op[2], wrWord: op[1], bitOp: op[0], bitVal: bv,
                    bitIdx: bi, wdata: d};
        @(negedge clk);
        cpuReq <= '0;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // read data stands for the one cycle after the read edge
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus(a, 4'h8, 1'b0, 3'h0, 16'h0000);
        check(cpuRdata, exp, "read data");
    endtask

    task automatic pulse(input int n);
        @(negedge clk);
        if (n < 22) periphIrq[n] <= 1'b1;
        else if (n == 22) clockedSerialIrq <= 1'b1;
        else serial2TxIrq <= 1'b1;
        @(negedge clk);
        periphIrq <= '0;
        clockedSerialIrq <= 1'b0;
        serial2TxIrq <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, reset and tests
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        cpuReq = '0;
        reset_n = 1'b0;
        globalIrqEnable = 1'b0;
        inServicePriority = 1'b1;
        periphIrq = '0;
        clockedSerialIrq = 1'b0;
        serial2TxIrq = 1'b0;
        extPin = '0;
        ackEnable = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (16) @(negedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 3; i++) rd(`IRQF_PEND_LOW0_ADDR + 16'(i), 8'h00);
        rd(`IRQF_MASK_LOW0_ADDR, 8'hFF);
        rd(16'hFFE3, `IRQF_UNMAPPED_READ);
        $display("test reset done");

        for (i = 0; i < 3; i++) bus(`IRQF_PEND_LOW0_ADDR + 16'(i), 4'h4, 1'b0, 3'h0, 16'h00FF);
        rd(`IRQF_PEND_LOW0_ADDR, 8'hFF);
        rd(`IRQF_PEND_HIGH0_ADDR, 8'hFF);
        rd(`IRQF_PEND_LOW1_ADDR, 8'h3F);
        bus(`IRQF_PEND_LOW0_ADDR, 4'h2, 1'b0, 3'h0, 16'hA55A);
        rd(`IRQF_PEND_LOW0_ADDR, 8'h5A);
        rd(`IRQF_PEND_HIGH0_ADDR, 8'hA5);
        for (i = 0; i < 3; i++) bus(`IRQF_PEND_LOW0_ADDR + 16'(i), 4'h4, 1'b0, 3'h0, 16'h0000);
        rd(`IRQF_PEND_LOW0_ADDR, 8'h00);
        for (i = 0; i < 8; i++) bus(`IRQF_PEND_LOW1_ADDR, 4'h1, 1'b1, 3'(i), 16'h0000);
        rd(`IRQF_PEND_LOW1_ADDR, 8'h3F);
        for (i = 0; i < 8; i++) bus(`IRQF_PEND_LOW1_ADDR, 4'h1, 1'b0, 3'(i), 16'h0000);
        rd(`IRQF_PEND_LOW1_ADDR, 8'h00);
        $display("test writes done");

        // every source lands on its own flag; the two serial lines share index 10
        for (i = 0; i < 24; i++) begin
            k = (i < 22) ? i : 10;
            pulse(i);
            rd(`IRQF_PEND_LOW0_ADDR + 16'(k / 8), 8'h01 << (k % 8));
            bus(`IRQF_PEND_LOW0_ADDR + 16'(k / 8), 4'h1, 1'b0, 3'(k % 8), 16'h0000);
            rd(`IRQF_PEND_LOW0_ADDR + 16'(k / 8), 8'h00);
        end
        $display("test sources done");

        // request and software clear in the same cycle
        @(negedge clk);
        periphIrq[0] <= 1'b1;
        cpuReq <= '{addr: `IRQF_PEND_LOW0_ADDR, rdEn: 1'b0, wrByte: 1'b0, wrWord: 1'b0, bitOp: 1'b1,
                    bitVal: 1'b0, bitIdx: 3'h0, wdata: 16'h0000};
        @(negedge clk);
        periphIrq <= '0;
        cpuReq <= '0;
        rd(`IRQF_PEND_LOW0_ADDR, 8'h01);
        bus(`IRQF_PEND_LOW0_ADDR, 4'h1, 1'b0, 3'h0, 16'h0000);
        $display("test collision done");

        bus(`IRQF_RISE_EDGE_ADDR, 4'h4, 1'b0, 3'h0, 16'h0001);
        @(negedge clk);
        extPin[0] <= 1'b1;
        for (i = 0; i < 12; i++) begin
            bus(`IRQF_PEND_LOW0_ADDR, 4'h8, 1'b0, 3'h0, 16'h0000);
            if (cpuRdata === 8'h02) break;
        end
        check(cpuRdata, 8'h02, "pin rising edge");
        bus(`IRQF_PEND_LOW0_ADDR, 4'h1, 1'b0, 3'h1, 16'h0000);
        extPin[0] <= 1'b0;
        repeat (10) @(negedge clk);
        rd(`IRQF_PEND_LOW0_ADDR, 8'h00);
        $display("test pins done");

        globalIrqEnable <= 1'b1;
        pulse(23);
        pulse(12);
        check({1'b0, grant}, 8'h00, "masked grant");
        bus(`IRQF_MASK_HIGH0_ADDR, 4'h4, 1'b0, 3'h0, 16'h00EB);
        check({1'b0, grant}, {2'b01, 5'h0A, 1'b1}, "equal level grant");
        bus(`IRQF_PRIO_HIGH0_ADDR, 4'h1, 1'b0, 3'h4, 16'h0000);
        check({1'b0, grant}, {2'b01, 5'h0C, 1'b0}, "high level grant");
        globalIrqEnable <= 1'b0;
        @(negedge clk);
        check({1'b0, grant}, 8'h00, "disabled grant");
        globalIrqEnable <= 1'b1;
        ackEnable <= 1'b1;
        // let the grant come back before waiting for the acknowledges to drain it
        @(negedge clk);
        for (i = 0; i < 40 && grant.valid !== 1'b0; i++) @(negedge clk);
        if (grant.valid !== 1'b0) begin
            n_fail++;
            $display("ERROR at %0t: grant never dropped", $time);
        end else begin
            rd(`IRQF_PEND_HIGH0_ADDR, 8'h00);
        end
        $display("test grant done");
        tally_and_finish();
    end
endmodule
